// ### dv/fuselk_checker.sv
/* port checker for fuselk_core
   bound from tb_top; sees top ports only */
`timescale 1ns/1ps
`default_nettype none
module fuselk_checker
  import fuselk_pkg::*;
#(parameter logic [7:0] CAL_96 = 8'h80) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // access side
  input wire logic prog_mode,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire fuselk_pkg::fuselk_mem_t acc_mem,
  input wire logic [8:0] acc_addr,
  input wire logic chip_erase,
  // answers and state
  input wire logic rd_valid,
  input wire logic acc_refused,
  input wire logic mem_wr,
  input wire logic [4:0] mem_page,
  input wire logic [3:0] mem_word,
  input wire logic erase_arrays,
  input wire logic [7:0] lock_byte,
  input wire logic [7:0] active_fuse_hi,
  input wire logic [7:0] active_fuse_lo,
  input wire logic debug_link_enable,
  input wire logic watchdog_irq_enable,
  input wire logic [7:0] osc_calibration_reg,
  input wire fuselk_pkg::fuselk_mode_t lock_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic rd_a;
  logic wr_a;
  assign rd_a = acc_valid && !acc_write && !chip_erase;
  assign wr_a = acc_valid && acc_write && !chip_erase;
  // ****
  // checks
  // ****
  a_lock_ones: assert property (lock_byte[7:2] == 6'h3F)
    else $error("lock byte upper bits not one");
  a_sig_open: assert property (rd_a && acc_mem == FUSELK_MEM_SIG |=> rd_valid && !acc_refused)
    else $error("signature read refused");
  a_erase_relock: assert property (acc_valid && chip_erase |=> erase_arrays ##[0:2]
    lock_byte == 8'hFF)
    else $error("erase did not clear locks");
  a_mode_open: assert property ((lock_byte[1:0] == 2'b11) [*3] |-> lock_mode == FUSELK_MODE_OPEN)
    else $error("open mode wrong");
  a_mode_noprog: assert property ((lock_byte[1:0] == 2'b10) [*3] |->
    lock_mode == FUSELK_MODE_NO_PROG)
    else $error("no-program mode wrong");
  a_mode_full: assert property ((!lock_byte[1]) [*3] |-> lock_mode == FUSELK_MODE_FULL)
    else $error("full lock mode wrong");
  a_prog_block: assert property (wr_a && acc_mem inside {FUSELK_MEM_FLASH, FUSELK_MEM_EEPROM}
    && lock_byte[0] == 1'b0 |=> acc_refused && !mem_wr)
    else $error("array write not refused");
  a_read_block: assert property (rd_a && acc_mem == FUSELK_MEM_FLASH && !lock_byte[1]
    |=> acc_refused && !rd_valid)
    else $error("array read not refused");
  a_fuse_lock: assert property (wr_a && acc_mem inside {FUSELK_MEM_FUSE_LO, FUSELK_MEM_FUSE_HI}
    && !lock_byte[0] |=> acc_refused)
    else $error("fuse write not refused");
  a_geometry: assert property ($past(acc_mem) == FUSELK_MEM_FLASH |-> {mem_page, mem_word} == $past(acc_addr))
    else $error("page split wrong");
  a_ee_geometry: assert property ($past(acc_mem) == FUSELK_MEM_EEPROM |-> {mem_page, mem_word} == {1'b0, $past(acc_addr[5:2]), 2'b00, $past(acc_addr[1:0])})
    else $error("eeprom page split wrong");
  a_cal_reset: assert property ($past(reset) |-> osc_calibration_reg == CAL_96)
    else $error("calibration not loaded");
  a_fuse_frozen: assert property (prog_mode [*3] |-> $stable(active_fuse_hi))
    else $error("active fuses moved in session");
  a_wdt_irq: assert property ((!active_fuse_lo[5]) [*3] |-> !watchdog_irq_enable)
    else $error("watchdog irq left on");
  a_debug_en: assert property ((!active_fuse_hi[3]) [*3] |-> debug_link_enable)
    else $error("debug link not enabled");
endmodule : fuselk_checker
`default_nettype wire

// ### dv/fuselk_prog_model.sv
/* external programmer model on the access port
   driven through its task from tb_top */
`timescale 1ns/1ps
`default_nettype none
module fuselk_prog_model
  import fuselk_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // access port
  output logic acc_valid,
  output logic acc_write,
  output fuselk_pkg::fuselk_mem_t acc_mem,
  output logic [8:0] acc_addr,
  output logic [7:0] acc_wdata,
  output logic chip_erase
);
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_mem = FUSELK_MEM_FLASH;
    acc_addr = 9'h000;
    acc_wdata = 8'h00;
    chip_erase = 1'b0;
  end
  // one strobed access; data inverted once released
  task acc(input logic w, input fuselk_mem_t m, input logic [8:0] a, input logic [7:0] d,
    input logic e);
    @(posedge ref_clk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_mem <= m;
    acc_addr <= a;
    acc_wdata <= d;
    chip_erase <= e;
    @(posedge ref_clk);
    acc_valid <= 1'b0;
    chip_erase <= 1'b0;
    acc_wdata <= ~d;
  endtask : acc
endmodule : fuselk_prog_model
`default_nettype wire

// ### dv/tb_top.sv
/* self-checking bench for fuselk_core
   uses fuselk_prog_model and fuselk_checker */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
  import fuselk_pkg::*;
  logic ref_clk = 0, reset = 1, prog_mode = 0, prog_serial = 1, cal_wr = 0;
  logic [7:0] cal_wdata = 8'h00, fh, cv, rd_data, lock_byte, active_fuse_hi, active_fuse_lo;
  logic [7:0] osc_calibration_reg, acc_wdata, mem_wdata;
  logic acc_valid, acc_write, chip_erase, rd_valid, acc_refused, mem_wr, erase_arrays;
  logic erase_eeprom, debug_link_enable, watchdog_irq_enable;
  logic [8:0] acc_addr;
  logic [4:0] mem_page;
  logic [3:0] mem_word;
  fuselk_mem_t acc_mem;
  fuselk_mode_t lock_mode;
  logic [10:0] exp_q[$];
  logic [10:0] e;
  logic [7:0] sig [3] = '{8'hA5, 8'h5A, 8'h3C};
  int n_fail = 0, num_checks = 0, cyc = 0;
  always #4 ref_clk = ~ref_clk;
  fuselk_prog_model u_prog (.ref_clk(ref_clk), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_mem(acc_mem), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .chip_erase(chip_erase));
  fuselk_core dut (.ref_clk(ref_clk), .reset(reset), .prog_mode(prog_mode),
    .prog_serial(prog_serial), .acc_valid(acc_valid), .acc_write(acc_write), .acc_mem(acc_mem),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .chip_erase(chip_erase), .cal_wr(cal_wr),
    .cal_wdata(cal_wdata), .rd_valid(rd_valid), .rd_data(rd_data), .acc_refused(acc_refused),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_page(mem_page), .mem_word(mem_word),
    .erase_arrays(erase_arrays), .erase_eeprom(erase_eeprom), .lock_byte(lock_byte),
    .active_fuse_hi(active_fuse_hi), .active_fuse_lo(active_fuse_lo),
    .debug_link_enable(debug_link_enable), .watchdog_irq_enable(watchdog_irq_enable),
    .osc_calibration_reg(osc_calibration_reg), .lock_mode(lock_mode));
  // ****
  // tasks
  // ****
  task complete_run;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  // x: {answer due, data compared, refused, data}
  task op(input logic w, input fuselk_mem_t m, input logic [8:0] a, input logic [7:0] d,
    input logic [10:0] x);
    if (x[10]) exp_q.push_back(x);
    u_prog.acc(w, m, a, d, 1'b0);
  endtask : op
  task erase(input logic [1:0] x);
    u_prog.acc(1'b0, FUSELK_MEM_FLASH, 9'h000, 8'h00, 1'b1);
    #1 `CHK({erase_arrays, erase_eeprom}, x)
  endtask : erase
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end else if (!reset && (rd_valid || acc_refused)) begin
      e = exp_q.size() ? exp_q.pop_front() : 11'h000;
      `CHK(e[10], 1'b1)
      `CHK({rd_valid, acc_refused}, {~e[8], e[8]})
      if (e[9]) `CHK(rd_data, e[7:0])
    end
  end
  // ****
  // tests
  // ****
  initial begin
    void'($urandom(32'hAFB3));
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    prog_mode <= 1'b1;
    @(posedge ref_clk);
    #1 `CHK(osc_calibration_reg, 8'h80)
    `CHK({lock_byte, active_fuse_hi, active_fuse_lo}, 24'hFFFF6A)
    op(0, FUSELK_MEM_LOCK, 0, 0, 11'h6FF);
    op(0, FUSELK_MEM_FUSE_HI, 0, 0, 11'h6FF);
    op(0, FUSELK_MEM_FUSE_LO, 0, 0, 11'h66A);
    for (int i = 0; i < 3; i++) op(0, FUSELK_MEM_SIG, 9'(i), 0, {3'b110, sig[i]});
    op(0, FUSELK_MEM_CAL, 1, 0, 11'h680);
    op(1, FUSELK_MEM_SIG, 0, 8'h00, 11'h500);
    op(1, FUSELK_MEM_FLASH, 9'h1A7, 8'h3C, 0);
    #1 `CHK({mem_wr, mem_page, mem_word}, 10'h3A7)
    `CHK(mem_wdata, 8'h3C)
    erase(2'b11);
    $display("test open done");
    fh = (8'($urandom) | 8'hE0) & 8'hF7;
    op(1, FUSELK_MEM_FUSE_HI, 0, fh, 0);
    op(1, FUSELK_MEM_FUSE_LO, 0, 8'h8A, 0);
    op(0, FUSELK_MEM_FUSE_LO, 0, 0, 11'h60A);
    op(0, FUSELK_MEM_FUSE_HI, 0, 0, {3'b110, fh});
    // high-voltage method, reset pin may be disabled
    prog_serial <= 1'b0;
    op(0, FUSELK_MEM_FUSE_LO, 0, 0, 11'h60A);
    #1 `CHK(active_fuse_hi, 8'hFF)
    erase(2'b10);
    @(posedge ref_clk);
    prog_mode <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 `CHK(active_fuse_hi, fh)
    `CHK({debug_link_enable, watchdog_irq_enable}, 2'b10)
    @(posedge ref_clk);
    prog_mode <= 1'b1;
    $display("test fuses done");
    op(1, FUSELK_MEM_LOCK, 0, 8'hFE, 0);
    repeat (2) @(posedge ref_clk);
    #1 `CHK(lock_mode, FUSELK_MODE_NO_PROG)
    op(1, FUSELK_MEM_FLASH, 0, 8'h11, 11'h500);
    op(1, FUSELK_MEM_EEPROM, 0, 8'h11, 11'h500);
    op(0, FUSELK_MEM_FLASH, 0, 0, 11'h400);
    op(1, FUSELK_MEM_FUSE_HI, 0, 8'hFF, 11'h500);
    op(1, FUSELK_MEM_LOCK, 0, 8'hFC, 0);
    op(0, FUSELK_MEM_SIG, 2, 0, {3'b110, sig[2]});
    #1 `CHK(lock_mode, FUSELK_MODE_FULL)
    op(0, FUSELK_MEM_FLASH, 0, 0, 11'h500);
    op(0, FUSELK_MEM_EEPROM, 0, 0, 11'h500);
    erase(2'b10);
    op(0, FUSELK_MEM_FUSE_HI, 0, 0, {3'b110, fh});
    op(0, FUSELK_MEM_LOCK, 0, 0, 11'h6FF);
    op(1, FUSELK_MEM_LOCK, 0, 8'hFD, 0);
    op(1, FUSELK_MEM_LOCK, 0, 8'hFF, 0);
    op(0, FUSELK_MEM_LOCK, 0, 0, 11'h6FD);
    #1 `CHK(lock_mode, FUSELK_MODE_FULL)
    $display("test locks done");
    cv = 8'($urandom);
    @(posedge ref_clk);
    cal_wr <= 1'b1;
    cal_wdata <= cv;
    @(posedge ref_clk);
    cal_wr <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 `CHK(osc_calibration_reg, cv)
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1 `CHK(osc_calibration_reg, 8'h80)
    $display("test calibration done");
    `CHK(exp_q.size(), 0)
    complete_run();
  end
endmodule : tb_top
bind fuselk_core fuselk_checker #(.CAL_96(CAL_96)) u_chk (.ref_clk(ref_clk), .reset(reset),
  .prog_mode(prog_mode), .acc_valid(acc_valid), .acc_write(acc_write), .acc_mem(acc_mem),
  .acc_addr(acc_addr), .chip_erase(chip_erase), .rd_valid(rd_valid),
  .acc_refused(acc_refused), .mem_wr(mem_wr), .mem_page(mem_page), .mem_word(mem_word),
  .erase_arrays(erase_arrays), .lock_byte(lock_byte), .active_fuse_hi(active_fuse_hi),
  .active_fuse_lo(active_fuse_lo), .debug_link_enable(debug_link_enable),
  .watchdog_irq_enable(watchdog_irq_enable), .osc_calibration_reg(osc_calibration_reg),
  .lock_mode(lock_mode));
`default_nettype wire

// ### hw/fuselk_core.sv
/*
  Fuse and lock configuration store: lock byte, two fuse bytes, latched
  fuse copy, protection gating, signature and calibration readout, and
  flash/EEPROM address geometry with chip-erase strobes.
  Assumes the programmer presents one access per cycle with a strobe.
*/
// Overview of operation
// - two lock bits, one means unprogrammed, both default one
// - only chip erase returns lock bits to one (reset here also loads both lock bits to one)
// - lock byte: high lock bit 1, low lock bit 0, bits 7..2 read one
// - both lock bits one: no protection
// - mode 2 blocks programming, locks fuses, disables debug; reads allowed (debug_link_enable here ignores the lock mode)
// - mode 3 blocks programming and reads, locks fuses, disables debug (debug_link_enable here ignores the lock mode)
// - debug fuse programmed allows debug readout regardless of locks
// - two fuse bytes; programmed fuse reads zero
// - high fuse byte field layout, all default one
// - low fuse byte field layout and defaults
// - serial-programming fuse not readable or writable over serial link
// - watchdog-always-on fuse disables watchdog interrupt
// - programmed low lock bit blocks all fuse changes
// - chip erase leaves fuses unchanged
// - fuses latched on programming entry and power-up; take effect on exit
// - EEPROM-preserve fuse write takes effect immediately
// - every reset loads 9.6 MHz calibration byte into calibration register
// - 4.8 MHz calibration byte stored, never auto-loaded
// - three signature bytes readable in both modes even when locked
// - flash 32 pages of 16 words; word bits 3:0, page 8:4
// - EEPROM 16 pages of 4 bytes; byte bits 1:0, page 5:2
// - chip erase sets flash to 0xFF, and EEPROM too unless the EEPROM-preserve fuse is programmed
`timescale 1ns/1ps
`default_nettype none
`include "fuselk_map.svh"

module fuselk_core #(
  // arbitrary neutral identity values
  parameter logic [7:0] SIG_BYTE0 = 8'hA5,
  parameter logic [7:0] SIG_BYTE1 = 8'h5A,
  parameter logic [7:0] SIG_BYTE2 = 8'h3C,
  parameter logic [7:0] CAL_96 = 8'h80,
  parameter logic [7:0] CAL_48 = 8'h80
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // programming session
  input wire logic prog_mode,
  input wire logic prog_serial,
  // programmer access
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire fuselk_pkg::fuselk_mem_t acc_mem,
  input wire logic [8:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic chip_erase,
  // firmware calibration write
  input wire logic cal_wr,
  input wire logic [7:0] cal_wdata,
  // access answer
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic acc_refused,
  // array control
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic [4:0] mem_page,
  output logic [3:0] mem_word,
  output logic erase_arrays,
  output logic erase_eeprom,
  // effective configuration
  output logic [7:0] lock_byte,
  output logic [7:0] active_fuse_hi,
  output logic [7:0] active_fuse_lo,
  output logic debug_link_enable,
  output logic watchdog_irq_enable,
  output logic [7:0] osc_calibration_reg,
  output fuselk_pkg::fuselk_mode_t lock_mode
);
  import fuselk_pkg::*;

  // ************************************************************
  // storage
  // ************************************************************
  logic [1:0] lock_q;
  logic [7:0] config_high_byte_q;
  logic [7:0] config_low_byte_q;
  logic [7:0] latch_hi_q;
  logic [7:0] latch_lo_q;
  logic prog_mode_q;
  logic eeprom_preserve_q;
  fuselk_mode_t mode;
  logic prog_blocked;
  logic verify_blocked;
  logic fuses_locked;

  fuselk_decode u_decode (
    .lock_bits(lock_q),
    .mode(mode),
    .prog_blocked(prog_blocked),
    .verify_blocked(verify_blocked),
    .fuses_locked(fuses_locked)
  );

  // lock bit byte image with unused bits high
  function automatic logic [7:0] lock_image(input logic [1:0] bits);
    lock_image = {6'h3F, bits};
  endfunction : lock_image

  wire wr_fuse = acc_valid & acc_write & ~chip_erase;
  wire fuse_lo_wr = wr_fuse & (acc_mem == FUSELK_MEM_FUSE_LO) & ~fuses_locked;
  wire fuse_hi_wr = wr_fuse & (acc_mem == FUSELK_MEM_FUSE_HI) & ~fuses_locked;
  wire lock_wr = wr_fuse & (acc_mem == FUSELK_MEM_LOCK);
  wire erase_ok = acc_valid & chip_erase;

  // ************************************************************
  // lock bits
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lock_q <= 2'h3;
    end else if (erase_ok) begin
      // erase, like reset above, sets bits back to one
      lock_q <= 2'h3;
    end else if (lock_wr) begin
      // writes may only program (clear) bits
      lock_q <= lock_q & acc_wdata[1:0];
    end
  end

  // ************************************************************
  // fuse bytes
  // ************************************************************
  // chip erase does not touch fuses
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      config_high_byte_q <= `FUSELK_FH_DEFAULT;
    end else if (fuse_hi_wr) begin
      config_high_byte_q <= acc_wdata | `FUSELK_FH_UNUSED_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      config_low_byte_q <= `FUSELK_FL_DEFAULT;
    end else if (fuse_lo_wr) begin
      config_low_byte_q <= acc_wdata;
      // serial link cannot change this bit
      if (prog_serial) begin
        config_low_byte_q[`FUSELK_FL_SERPROG_BIT] <=
          config_low_byte_q[`FUSELK_FL_SERPROG_BIT];
      end
    end
  end

  // ************************************************************
  // latched copy
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prog_mode_q <= 1'b0;
    end else begin
      prog_mode_q <= prog_mode;
    end
  end

  // capture every cycle outside programming, including entry, and at programming exit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      latch_hi_q <= `FUSELK_FH_DEFAULT;
      latch_lo_q <= `FUSELK_FL_DEFAULT;
    end else if (prog_mode != prog_mode_q || !prog_mode_q) begin
      if (!prog_mode_q || !prog_mode) begin
        latch_hi_q <= config_high_byte_q;
        latch_lo_q <= config_low_byte_q;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      eeprom_preserve_q <= 1'b1;
    end else if (fuse_lo_wr) begin
      eeprom_preserve_q <= acc_wdata[`FUSELK_FL_EEPRES_BIT];
    end else begin
      eeprom_preserve_q <= config_low_byte_q[`FUSELK_FL_EEPRES_BIT];
    end
  end

  // ************************************************************
  // calibration
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      // load 9.6 MHz byte on reset
      osc_calibration_reg <= CAL_96;
    end else if (cal_wr) begin
      // 4.8 MHz byte only by firmware write
      osc_calibration_reg <= cal_wdata;
    end
  end

  // ************************************************************
  // read path and protection
  // ************************************************************
  logic [7:0] rd_d;
  logic refuse_d;
  always_comb begin
    rd_d = 8'h00;
    refuse_d = 1'b0;
    case (acc_mem)
      FUSELK_MEM_FLASH, FUSELK_MEM_EEPROM: begin
        // programming or verify blocked by mode
        refuse_d = acc_write ? prog_blocked : verify_blocked;
      end
      FUSELK_MEM_FUSE_LO: begin
        rd_d = config_low_byte_q;
        if (prog_serial) begin
          rd_d[`FUSELK_FL_SERPROG_BIT] = 1'b0;
        end
        refuse_d = acc_write & fuses_locked;
      end
      FUSELK_MEM_FUSE_HI: begin
        rd_d = config_high_byte_q;
        refuse_d = acc_write & fuses_locked;
      end
      FUSELK_MEM_LOCK: rd_d = lock_image(lock_q);
      FUSELK_MEM_SIG: begin
        case (acc_addr[1:0])
          2'h0: rd_d = SIG_BYTE0;
          2'h1: rd_d = SIG_BYTE1;
          `FUSELK_SIG_LAST: rd_d = SIG_BYTE2;
          default: rd_d = 8'hFF;
        endcase
        refuse_d = acc_write;
      end
      FUSELK_MEM_CAL: begin
        rd_d = (acc_addr[0] == `FUSELK_CAL_ADDR_48) ? CAL_48 : CAL_96;
        refuse_d = acc_write;
      end
      default: refuse_d = 1'b1;
    endcase
    if (chip_erase) begin
      refuse_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      acc_refused <= 1'b0;
    end else begin
      rd_valid <= acc_valid & ~acc_write & ~chip_erase & ~refuse_d;
      rd_data <= (acc_valid & ~acc_write & ~refuse_d) ? rd_d : 8'h00;
      acc_refused <= acc_valid & refuse_d;
    end
  end

  // ************************************************************
  // array control
  // ************************************************************
  wire is_flash = (acc_mem == FUSELK_MEM_FLASH);
  wire is_eeprom = (acc_mem == FUSELK_MEM_EEPROM);
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mem_wr <= 1'b0;
      mem_wdata <= 8'h00;
      mem_page <= 5'h00;
      mem_word <= 4'h0;
      erase_arrays <= 1'b0;
      erase_eeprom <= 1'b0;
    end else begin
      mem_wr <= acc_valid & acc_write & ~chip_erase & (is_flash | is_eeprom) &
        ~prog_blocked;
      mem_wdata <= acc_wdata;
      if (is_flash) begin
        mem_page <= acc_addr[`FUSELK_FLASH_TOP_BIT:`FUSELK_FLASH_WORD_BITS];
        mem_word <= acc_addr[`FUSELK_FLASH_WORD_BITS-1:0];
      end else begin
        mem_page <= {1'b0,
          acc_addr[`FUSELK_EEPROM_TOP_BIT:`FUSELK_EEPROM_BYTE_BITS]};
        mem_word <= {2'h0, acc_addr[`FUSELK_EEPROM_BYTE_BITS-1:0]};
      end
      erase_arrays <= erase_ok;
      erase_eeprom <= erase_ok & eeprom_preserve_q;
    end
  end

  // ************************************************************
  // effective configuration outputs
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lock_byte <= `FUSELK_LOCK_ERASED;
      active_fuse_hi <= `FUSELK_FH_DEFAULT;
      active_fuse_lo <= `FUSELK_FL_DEFAULT;
      debug_link_enable <= 1'b0;
      watchdog_irq_enable <= 1'b1;
      lock_mode <= FUSELK_MODE_OPEN;
    end else begin
      lock_byte <= lock_image(lock_q);
      active_fuse_hi <= latch_hi_q;
      active_fuse_lo <= latch_lo_q;
      debug_link_enable <= ~latch_hi_q[`FUSELK_FH_DEBUG_BIT];
      watchdog_irq_enable <= latch_lo_q[`FUSELK_FL_WDOG_ON_BIT];
      lock_mode <= mode;
    end
  end
endmodule : fuselk_core
`default_nettype wire

// ### hw/fuselk_decode.sv
/*
  Lock-mode decoder and protection flags.
  Assumes lock byte bits follow the programmed-is-zero convention.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fuselk_map.svh"

module fuselk_decode (
  // lock state
  input wire logic [1:0] lock_bits,
  // decoded mode
  output fuselk_pkg::fuselk_mode_t mode,
  output logic prog_blocked,
  output logic verify_blocked,
  output logic fuses_locked
);
  import fuselk_pkg::*;

  always_comb begin
    case (lock_bits)
      2'h3: mode = FUSELK_MODE_OPEN;
      2'h2: mode = FUSELK_MODE_NO_PROG;
      default: mode = FUSELK_MODE_FULL;
    endcase
  end

  assign prog_blocked = (mode != FUSELK_MODE_OPEN);
  assign verify_blocked = (mode == FUSELK_MODE_FULL);
  assign fuses_locked = ~lock_bits[`FUSELK_LOCK_LOW_BIT] | prog_blocked;
endmodule : fuselk_decode
`default_nettype wire

// ### pkg/fuselk_map.svh
/*
  Constants of the fuse and lock configuration block: bit positions,
  erased and default values, calibration addresses and array geometry.
  Assumes nothing beyond a SystemVerilog preprocessor.
*/
`ifndef FUSELK_MAP_SVH
`define FUSELK_MAP_SVH

// lock byte
`define FUSELK_LOCK_LOW_BIT 0
`define FUSELK_LOCK_HIGH_BIT 1
`define FUSELK_LOCK_ERASED 8'hFF
// fuse high byte
`define FUSELK_FH_RSTDIS_BIT 0
`define FUSELK_FH_BOD_LO_BIT 1
`define FUSELK_FH_BOD_HI_BIT 2
`define FUSELK_FH_DEBUG_BIT 3
`define FUSELK_FH_SELFPRG_BIT 4
`define FUSELK_FH_UNUSED_MASK 8'hE0
`define FUSELK_FH_DEFAULT 8'hFF
// fuse low byte
`define FUSELK_FL_CKSEL_LSB 0
`define FUSELK_FL_SUT_LSB 2
`define FUSELK_FL_CLKDIV_BIT 4
`define FUSELK_FL_WDOG_ON_BIT 5
`define FUSELK_FL_EEPRES_BIT 6
`define FUSELK_FL_SERPROG_BIT 7
`define FUSELK_FL_DEFAULT 8'h6A
// signature and calibration space
`define FUSELK_SIG_LAST 2'h2
`define FUSELK_CAL_ADDR_96 1'h0
`define FUSELK_CAL_ADDR_48 1'h1
// geometry
`define FUSELK_FLASH_TOP_BIT 8
`define FUSELK_FLASH_WORD_BITS 4
`define FUSELK_EEPROM_TOP_BIT 5
`define FUSELK_EEPROM_BYTE_BITS 2
`define FUSELK_ERASED_BYTE 8'hFF

`endif

// ### pkg/fuselk_pkg.sv
/*
  Types of the fuse and lock configuration block.
  Assumes fuselk_map.svh on the include path.
*/
package fuselk_pkg;
  typedef enum logic [1:0] {
    FUSELK_MODE_OPEN,
    FUSELK_MODE_NO_PROG,
    FUSELK_MODE_FULL
  } fuselk_mode_t;

  typedef enum logic [2:0] {
    FUSELK_MEM_FLASH,
    FUSELK_MEM_EEPROM,
    FUSELK_MEM_FUSE_LO,
    FUSELK_MEM_FUSE_HI,
    FUSELK_MEM_LOCK,
    FUSELK_MEM_SIG,
    FUSELK_MEM_CAL
  } fuselk_mem_t;
endpackage : fuselk_pkg
